// [rtl/svd_ctrl.sv]
// Control, status and event logic of the supply voltage detector.
// Assumes an analog comparator whose output is high while the sensed
// voltage is at or above the selected trip point, and stability levels
// from the band gap and internal reference, all asynchronous.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module svd_ctrl
  import svd_pkg::*;
#(
  parameter int ADDR_W = 4
)(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic      [15:0]       reg_rdata,
  input  wire logic              cmp_trip,
  input  wire logic              bandgap_ok,
  input  wire logic              reference_ok,
  input  wire logic              idle_mode,
  output logic                   detector_power,
  output logic      [3:0]        trip_level_select,
  output logic                   external_sense_input_sel,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 2 || ADDR_W > 16)
  begin : g_bad_addr
    $error("ADDR_W must lie between 2 and 16");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic lvl_ok(input logic [3:0] lvl);
    lvl_ok = (lvl >= SVD_LVL_MIN);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                detector_on_q;
  logic                halt_in_idle_q;
  logic                crossing_direction_q;
  logic [3:0]          trip_level_select_q;
  logic [SVD_ST_W-1:0] stat_q;
  logic [SVD_ST_W-1:0] stat_d;
  logic [SVD_ST_W-1:0] mask_q;
  logic [15:0]         rdata_q;
  logic                cmp_meta_q;
  logic                cmp_sync_q;
  logic                bg_meta_q;
  logic                bg_sync_q;
  logic                ref_meta_q;
  logic                ref_sync_q;
  logic                bg_prev_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic sel_ctrl = (reg_addr == ADDR_W'(SVD_OFS_CTRL));
  wire logic sel_stat = (reg_addr == ADDR_W'(SVD_OFS_STATUS));
  wire logic sel_mask = (reg_addr == ADDR_W'(SVD_OFS_MASK));
  wire logic wr_ctrl  = reg_we && sel_ctrl;
  wire logic wr_stat  = reg_we && sel_stat;
  wire logic wr_mask  = reg_we && sel_mask;
  wire logic rd_stat  = reg_re && sel_stat;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // enable and idle halt
  wire logic active = detector_on_q && !(halt_in_idle_q && idle_mode);

  wire logic cond_hit   = crossing_direction_q ? cmp_sync_q : !cmp_sync_q;
  wire logic event_live = active && lvl_ok(trip_level_select_q) && cond_hit;

  wire logic trip_set = event_live && ref_sync_q;
  wire logic bg_set   = bg_sync_q && !bg_prev_q;

  // trip flag clear by read or written zero only when not live; bandgap flag clear by either at any time
  wire logic trip_clr = (rd_stat || (wr_stat && !reg_wdata[SVD_ST_TRIP])) && !event_live;
  wire logic bg_clr   = rd_stat || (wr_stat && !reg_wdata[SVD_ST_BG]);

  // Set wins over clear
  always_comb
  begin
    stat_d = stat_q;
    if (trip_clr)
    begin
      stat_d[SVD_ST_TRIP] = 1'b0;
    end
    if (bg_clr)
    begin
      stat_d[SVD_ST_BG] = 1'b0;
    end
    if (trip_set)
    begin
      stat_d[SVD_ST_TRIP] = 1'b1;
    end
    if (bg_set)
    begin
      stat_d[SVD_ST_BG] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // control read image
  wire logic [15:0] ctrl_img = {detector_on_q, 1'b0, halt_in_idle_q, 1'b0,
                                crossing_direction_q, bg_sync_q, ref_sync_q,
                                event_live, 4'h0, trip_level_select_q};
  wire logic [15:0] rd_mux = sel_ctrl ? ctrl_img :
                             sel_stat ? {14'h0000, stat_q} :
                             sel_mask ? {14'h0000, mask_q} : 16'h0000;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // two-stage sync of comparator, bandgap and reference levels
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmp_meta_q <= SVD_RST_BIT;
      cmp_sync_q <= SVD_RST_BIT;
      bg_meta_q  <= SVD_RST_BIT;
      bg_sync_q  <= SVD_RST_BIT;
      ref_meta_q <= SVD_RST_BIT;
      ref_sync_q <= SVD_RST_BIT;
      bg_prev_q  <= SVD_RST_BIT;
    end
    else
    begin
      cmp_meta_q <= cmp_trip;
      cmp_sync_q <= cmp_meta_q;
      bg_meta_q  <= bandgap_ok;
      bg_sync_q  <= bg_meta_q;
      ref_meta_q <= reference_ok;
      ref_sync_q <= ref_meta_q;
      bg_prev_q  <= bg_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // writable fields only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      detector_on_q        <= SVD_RST_BIT;
      halt_in_idle_q       <= SVD_RST_BIT;
      crossing_direction_q <= SVD_RST_BIT;
      trip_level_select_q  <= SVD_RST_LVL;
    end
    else if (wr_ctrl)
    begin
      detector_on_q        <= reg_wdata[SVD_ON_BIT];
      halt_in_idle_q       <= reg_wdata[SVD_HALT_BIT];
      crossing_direction_q <= reg_wdata[SVD_DIR_BIT];
      trip_level_select_q  <= reg_wdata[SVD_LVL_LSB +: SVD_LVL_W];
    end
  end

  // ----------------------------------------------------------------
  // Status, mask, read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stat_q  <= SVD_RST_ST;
      mask_q  <= SVD_RST_ST;
      rdata_q <= SVD_RST_RD;
    end
    else
    begin
      stat_q  <= stat_d;
      rdata_q <= reg_re ? rd_mux : SVD_RST_RD;
      if (wr_mask)
      begin
        mask_q <= reg_wdata[SVD_ST_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata                = rdata_q;
  assign detector_power           = active;
  assign trip_level_select        = trip_level_select_q;
  assign external_sense_input_sel = (trip_level_select_q == SVD_LVL_EXT);
  assign irq                      = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_live_ref;
    event_live && ref_sync_q;
  endsequence

  property p_trip_sets;
    @(posedge clk_sys) disable iff (rst)
      s_live_ref |=> stat_q[SVD_ST_TRIP];
  endproperty
  a_trip_sets : assert property (p_trip_sets)
    else $error("trip event did not set flag");

  property p_off_quiet;
    @(posedge clk_sys) disable iff (rst)
      !detector_on_q |-> !detector_power && !event_live;
  endproperty
  a_off_quiet : assert property (p_off_quiet)
    else $error("detector active while disabled");

  property p_idle_halt;
    @(posedge clk_sys) disable iff (rst)
      halt_in_idle_q && idle_mode |-> !detector_power && !event_live;
  endproperty
  a_idle_halt : assert property (p_idle_halt)
    else $error("detector active in idle with halt set");

  property p_dir_live;
    @(posedge clk_sys) disable iff (rst)
      active && lvl_ok(trip_level_select_q)
      |-> event_live == (cmp_sync_q == crossing_direction_q);
  endproperty
  a_dir_live : assert property (p_dir_live)
    else $error("live event disagrees with direction");

  property p_bg_read;
    @(posedge clk_sys) disable iff (rst)
      reg_re && sel_ctrl |=> reg_rdata[SVD_BG_BIT] == $past(bg_sync_q)
                         && reg_rdata[SVD_LIVE_BIT] == $past(event_live);
  endproperty
  a_bg_read : assert property (p_bg_read)
    else $error("control read shows wrong stability or live bit");

  property p_ref_gate;
    @(posedge clk_sys) disable iff (rst)
      $rose(stat_q[SVD_ST_TRIP]) |-> $past(ref_sync_q);
  endproperty
  a_ref_gate : assert property (p_ref_gate)
    else $error("flag set with reference unstable");

  property p_level_write;
    @(posedge clk_sys) disable iff (rst)
      wr_ctrl |=> trip_level_select == $past(reg_wdata[3:0])
              && external_sense_input_sel == ($past(reg_wdata[3:0]) == 4'hf);
  endproperty
  a_level_write : assert property (p_level_write)
    else $error("level field not taken from write");

  property p_flag_hold;
    @(posedge clk_sys) disable iff (rst)
      stat_q[SVD_ST_TRIP] && event_live |=> stat_q[SVD_ST_TRIP];
  endproperty
  a_flag_hold : assert property (p_flag_hold)
    else $error("flag cleared while event live");

  property p_unimpl_zero;
    @(posedge clk_sys) disable iff (rst)
      reg_re && sel_ctrl |=> (reg_rdata & 16'h50f0) == 16'h0000;
  endproperty
  a_unimpl_zero : assert property (p_unimpl_zero)
    else $error("unimplemented control bits read nonzero");

  sequence s_cmp_steady;
    cmp_trip [*3];
  endsequence

  property p_cmp_sync;
    @(posedge clk_sys) disable iff (rst)
      s_cmp_steady |-> cmp_sync_q;
  endproperty
  a_cmp_sync : assert property (p_cmp_sync)
    else $error("comparator sync did not follow input");

endmodule

`default_nettype wire

// [rtl/svd_pkg.sv]
// Package for the supply voltage detector control block.
// Assumes a 16-bit register port with word indices, one system clock.
package svd_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] SVD_OFS_CTRL   = 4'h0;
  localparam logic [3:0] SVD_OFS_STATUS = 4'h1;
  localparam logic [3:0] SVD_OFS_MASK   = 4'h2;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int SVD_ON_BIT   = 15;
  localparam int SVD_HALT_BIT = 13;
  localparam int SVD_DIR_BIT  = 11;
  localparam int SVD_BG_BIT   = 10;
  localparam int SVD_REF_BIT  = 9;
  localparam int SVD_LIVE_BIT = 8;
  localparam int SVD_LVL_LSB  = 0;
  localparam int SVD_LVL_W    = 4;

  localparam logic [3:0] SVD_LVL_EXT = 4'hf;
  localparam logic [3:0] SVD_LVL_MIN = 4'h4;

  // Bits that read back anything at all
  localparam logic [15:0] SVD_CTRL_RMASK = 16'haf0f;
  // Bits software may write
  localparam logic [15:0] SVD_CTRL_WMASK = 16'ha80f;

  // ----------------------------------------------------------------
  // Status and mask fields
  // ----------------------------------------------------------------
  localparam int SVD_ST_TRIP = 0;
  localparam int SVD_ST_BG   = 1;
  localparam int SVD_ST_W    = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic             SVD_RST_BIT  = 1'b0;
  localparam logic [3:0]       SVD_RST_LVL  = 4'h0;
  localparam logic [SVD_ST_W-1:0] SVD_RST_ST = 2'h0;
  localparam logic [15:0]      SVD_RST_RD   = 16'h0000;

endpackage

// [testbench/svd_analog_model.sv]
// Behavioural model of the detector comparator and its references.
// Assumes detector_power from svd_ctrl; sense levels come from the bench.
`timescale 1ns/1ps
`default_nettype none

module svd_analog_model #(
  parameter int BG_DLY  = 6,
  parameter int REF_DLY = 20
)(
  input  wire logic       clk_sys,
  input  wire logic       detector_power,
  input  wire logic [3:0] trip_level_select,
  input  wire logic       external_sense_input_sel,
  input  wire logic [3:0] sense_level,
  input  wire logic [3:0] pin_level,
  output logic            cmp_trip,
  output logic            bandgap_ok,
  output logic            reference_ok
);
  int   settle_q = 0;
  logic junk_q   = 1'b0;

  // ----------------------------------------------------------------
  // Settling after power up
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    settle_q <= detector_power ? settle_q + 1 : 0;
    junk_q   <= ~junk_q;
  end

  assign bandgap_ok   = settle_q >= BG_DLY;
  assign reference_ok = settle_q >= REF_DLY;
  // Toggles while unpowered, never a steady level
  assign cmp_trip = !detector_power ? junk_q :
                    external_sense_input_sel ? pin_level[3] :
                    (sense_level >= trip_level_select);
endmodule

`default_nettype wire

// [testbench/svd_ctrl_bench.sv]
// Self-checking bench for svd_ctrl with the analog model.
// Assumes a 20 MHz clock and the register map of svd_pkg.
`timescale 1ns/1ps
`default_nettype none

module svd_ctrl_bench
  import svd_pkg::*;
;
  logic        clk_sys     = 1'b0;
  logic        rst         = 1'b1;
  logic [3:0]  reg_addr    = 4'h0;
  logic [15:0] reg_wdata   = 16'h0000;
  logic        reg_we      = 1'b0;
  logic        reg_re      = 1'b0;
  logic        idle_mode   = 1'b0;
  logic [3:0]  sense_level = 4'h0;
  logic [3:0]  pin_level   = 4'h0;
  logic [15:0] reg_rdata;
  logic [15:0] rd_v;
  logic [3:0]  trip_level_select;
  logic        cmp_trip;
  logic        bandgap_ok;
  logic        reference_ok;
  logic        detector_power;
  logic        external_sense_input_sel;
  logic        irq;
  int          n_mismatch  = 0;
  int          check_count = 0;

  always #25 clk_sys = ~clk_sys;

  svd_ctrl dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .cmp_trip(cmp_trip), .bandgap_ok(bandgap_ok), .reference_ok(reference_ok),
    .idle_mode(idle_mode), .detector_power(detector_power),
    .trip_level_select(trip_level_select),
    .external_sense_input_sel(external_sense_input_sel), .irq(irq));

  svd_analog_model model (.clk_sys(clk_sys), .detector_power(detector_power),
    .trip_level_select(trip_level_select),
    .external_sense_input_sel(external_sense_input_sel), .sense_level(sense_level),
    .pin_level(pin_level), .cmp_trip(cmp_trip), .bandgap_ok(bandgap_ok),
    .reference_ok(reference_ok));

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk_sys);
    reg_we    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk_sys);
    reg_re   <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask

  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 50)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk({15'h0, irq}, {15'h0, e});
    if (n == 50)
      report_and_stop();
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(SVD_OFS_CTRL);
    chk(rd_v, 16'h0000);
    wr(SVD_OFS_CTRL, 16'h7fff);
    rd(SVD_OFS_CTRL);
    chk(rd_v, 16'h280f);
    wr(4'h3, 16'hffff);
    rd(4'h3);
    chk(rd_v, 16'h0000);
    wr(SVD_OFS_CTRL, 16'h0000);
    chk({15'h0, detector_power}, 16'h0000);
    $display("test access done");
    sense_level <= 4'hf;
    wr(SVD_OFS_CTRL, 16'h8804);
    chk({15'h0, detector_power}, 16'h0001);
    repeat (10) @(posedge clk_sys);
    rd(SVD_OFS_CTRL);
    chk(rd_v & 16'h0700, 16'h0500);
    sense_level <= 4'h0;
    repeat (30) @(posedge clk_sys);
    rd(SVD_OFS_CTRL);
    chk(rd_v & 16'h0700, 16'h0600);
    // Firmware clears the flag before first use
    rd(SVD_OFS_STATUS);
    chk(rd_v, 16'h0002);
    // Interrupt only after the reference is stable
    wr(SVD_OFS_MASK, 16'h0001);
    $display("test stability done");
    for (int d = 0; d < 2; d++)
    begin
      sense_level <= d ? 4'h2 : 4'hc;
      wr(SVD_OFS_CTRL, d ? 16'h8808 : 16'h8008);
      repeat (4) @(posedge clk_sys);
      rd(SVD_OFS_STATUS);
      chk({15'h0, irq}, 16'h0000);
      sense_level <= d ? 4'hc : 4'h2;
      wait_irq(1'b1);
      rd(SVD_OFS_CTRL);
      chk(rd_v & 16'h0100, 16'h0100);
      wr(SVD_OFS_STATUS, 16'h0000);
      #100 chk({15'h0, irq}, 16'h0001);
      sense_level <= d ? 4'h2 : 4'hc;
      repeat (4) @(posedge clk_sys);
      wr(SVD_OFS_MASK, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      wr(SVD_OFS_MASK, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      rd(SVD_OFS_STATUS);
      chk(rd_v & 16'h0001, 16'h0001);
      chk({15'h0, irq}, 16'h0000);
    end
    $display("test events done");
    sense_level <= 4'hc;
    wr(SVD_OFS_CTRL, 16'ha808);
    idle_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk({15'h0, detector_power}, 16'h0000);
    rd(SVD_OFS_CTRL);
    chk(rd_v & 16'h0100, 16'h0000);
    wr(SVD_OFS_CTRL, 16'h8808);
    chk({15'h0, detector_power}, 16'h0001);
    idle_mode <= 1'b0;
    $display("test idle done");
    // Sense above every level, so only levels below 4 and the pin code stay quiet
    sense_level <= 4'hf;
    for (int lv = 0; lv < 16; lv++)
    begin
      wr(SVD_OFS_CTRL, 16'h8800 | 16'(lv));
      chk({12'h0, trip_level_select}, 16'(lv));
      chk({15'h0, external_sense_input_sel}, {15'h0, lv == 15});
      repeat (4) @(posedge clk_sys);
      rd(SVD_OFS_CTRL);
      chk(rd_v & 16'h0100, (lv >= 4 && lv != 15) ? 16'h0100 : 16'h0000);
    end
    $display("test levels done");
    // Flag still set; restart detector so reference is unstable
    wr(SVD_OFS_CTRL, 16'h0000);
    wr(SVD_OFS_CTRL, 16'h8808);
    repeat (4) @(posedge clk_sys);
    wr(SVD_OFS_STATUS, 16'h0000);
    chk({15'h0, irq}, 16'h0001);
    rd(SVD_OFS_CTRL);
    chk(rd_v & 16'h0300, 16'h0100);
    sense_level <= 4'h0;
    repeat (4) @(posedge clk_sys);
    wr(SVD_OFS_STATUS, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    $display("test clear done");
    report_and_stop();
  end
endmodule

`default_nettype wire
